//--- srt_defines.svh
`ifndef SRT_DEFINES_SVH
`define SRT_DEFINES_SVH

// ==========================================================
// Transmit clock divider
`define SRT_SYS_CLOCK_KHZ     4000
`define SRT_TX_CLOCK_KHZ      500
`define SRT_DIV_CYCLE         (`SRT_SYS_CLOCK_KHZ / `SRT_TX_CLOCK_KHZ)
`define SRT_DIV_PRESET        4'h8
`define SRT_DIV_MAX           4'hf
`define SRT_DIV_TAP           2

// ==========================================================
// Input buffer
`define SRT_BUF_WORDS         16
`define SRT_BUF_ADDR_W        4
`define SRT_WORD_W            16
`define SRT_ADDR_RESET        4'h0

// ==========================================================
// Idle frame loop
`define SRT_IDLE_W            8
`define SRT_IDLE_PATTERN      8'h7e
`define SRT_IDLE_ROTATE       2
`define SRT_IDLE_HOLD_RESET   8'h7e

`endif

//--- srt_pkg.sv
package srt_pkg;
  typedef logic [3:0]  srt_addr_t;
  typedef logic [15:0] srt_word_t;
  typedef logic [7:0]  srt_byte_t;
  typedef enum logic [1:0]
  {
    SRT_LD_IDLE = 2'b00,
    SRT_LD_ARM  = 2'b01,
    SRT_LD_WAIT = 2'b10
  } srt_idle_load_t;
endpackage : srt_pkg

//--- srt_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "srt_defines.svh"

module srt_clock_divider
(
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic zero_insert_pause_n,
  output logic      divider_bit2,
  output logic      tx_rise,
  output logic      gated_tx_rise
);
  import srt_pkg::*;

  logic [3:0] count;
  logic       carry_n;

  // ==========================================================
  // Divider
  assign carry_n = ~(count == `SRT_DIV_MAX);

  // Inverted carry reloads the preset: eight states per period
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      count <= `SRT_DIV_PRESET;
    else if (!carry_n)
      count <= `SRT_DIV_PRESET;
    else
      count <= count + 4'h1;
  end

  // Bit 2 is high for counts c..f, low for 8..b: even split
  assign divider_bit2 = count[`SRT_DIV_TAP];

  // Rising edge of the transmit clock happens as count goes b -> c
  assign tx_rise       = (count == 4'hb);
  assign gated_tx_rise = tx_rise & zero_insert_pause_n;

  chk_div_period: assert property (@(posedge CLOCK)
    disable iff (RST) tx_rise |=> !tx_rise [*7] ##1 tx_rise)
    else $error("Transmit clock period is not eight cycles");
  chk_div_duty: assert property (@(posedge CLOCK)
    disable iff (RST) $rose(divider_bit2) |->
      divider_bit2 [*4] ##1 !divider_bit2)
    else $error("Transmit clock high time is not four cycles");
endmodule : srt_clock_divider
`default_nettype wire

//--- srt_tx_front_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "srt_defines.svh"

// Functional notes
// - Transmit clock is system clock divided by eight, 500 kHz from 4 MHz.
// - Divider counts to maximum; inverted carry reloads eight next clock.
// - Transmit clock is divider bit two, giving an even duty cycle.
// - Free-running and gated clocks; gated one skips a cycle during pause.
// - Serial data sent at half a megabit, without receiver permission.
// - No error recovery: no retransmission or acknowledgement handling.
// - 16x16 buffer, address selector, read/write counters, comparator.
// - During load, write counter addresses memory, steps per strobe.
// - Match flag low when addresses differ, high when buffer empty.
// - After write cycle, memory address returns to the read counter.
// - Read counter advances each time a word moves to shift register.
// - Both counters clear at reset and on idle sync loss.
// - Idle byte held in register, moved to shifter on gated clock.
// - Shifter last stage is idle output and feeds back to its input.
// - Idle stream deserialised and compared against pattern rotated by two.
// - Match gives idle strobe at start of each idle frame.
// - Pause asserted after five ones; zero inserted, gated clock skips.
module srt_tx_front_end
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic              ZERO_INSERT_PAUSE_N,
  input  wire logic              LOAD_WORDS_CMD_N,
  input  wire logic              WRITE_STROBE,
  input  wire srt_pkg::srt_word_t WRITE_DATA,
  input  wire logic              WORD_TAKE,
  input  wire logic              SYNC_LOST,
  input  wire logic              LOAD_IDLE,
  input  wire srt_pkg::srt_byte_t IDLE_DATA,
  output logic                   TX_CLOCK,
  output logic                   GATED_TX_CLOCK,
  output logic                   TX_RISE,
  output logic                   GATED_TX_RISE,
  output srt_pkg::srt_word_t     READ_WORD,
  output logic                   BUFFER_ADDR_MATCH,
  output srt_pkg::srt_addr_t     WRITE_ADDR,
  output srt_pkg::srt_addr_t     READ_ADDR,
  output logic                   IDLE_STREAM,
  output logic                   IDLE_STROBE
);
  import srt_pkg::*;

  // Byte rotate left by n, used to strap the compare pattern
  function automatic srt_byte_t rotl(input srt_byte_t v, input int n);
    srt_byte_t r;
    r = v;
    for (int i = 0; i < n; i++)
      r = {r[6:0], r[7]};
    return r;
  endfunction : rotl

  logic           divider_bit2;
  logic           tx_rise;
  logic           gated_tx_rise;
  logic           gated_level;
  logic           load_active;
  logic           load_cmd_q;
  srt_addr_t      write_addr;
  srt_addr_t      read_addr;
  srt_addr_t      mem_addr;
  srt_word_t      mem [`SRT_BUF_WORDS];
  srt_word_t      read_word;
  srt_byte_t      idle_hold_reg;
  srt_byte_t      idle_tx_shifter;
  srt_byte_t      idle_rx_deserializer;
  logic           idle_pending;
  logic           idle_strobe;
  srt_idle_load_t idle_state;
  srt_idle_load_t next_idle_state;

  // ==========================================================
  // Transmit clock
  srt_clock_divider u_div
  (
    .CLOCK               (CLOCK),
    .RST                 (RST),
    .zero_insert_pause_n (ZERO_INSERT_PAUSE_N),
    .divider_bit2        (divider_bit2),
    .tx_rise             (tx_rise),
    .gated_tx_rise       (gated_tx_rise)
  );

  // Gated copy holds low for the skipped period so no edge appears
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      gated_level <= 1'b0;
    else if (gated_tx_rise)
      gated_level <= 1'b1;
    else if (tx_rise)
      gated_level <= 1'b0;
    else if (!divider_bit2)
      gated_level <= 1'b0;
  end

  assign TX_CLOCK       = divider_bit2;
  assign GATED_TX_CLOCK = gated_level & divider_bit2;
  assign TX_RISE        = tx_rise;
  assign GATED_TX_RISE  = gated_tx_rise;

  // ==========================================================
  // Input buffer load window
  // Frames go out once; nothing here waits for an acknowledgement
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      load_cmd_q <= 1'b0;
    else
      load_cmd_q <= ~LOAD_WORDS_CMD_N;
  end

  // Window opens two clocks after command start, closes after its end
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      load_active <= 1'b0;
    else if (load_cmd_q && !LOAD_WORDS_CMD_N)
      load_active <= 1'b1;
    else if (!load_cmd_q && LOAD_WORDS_CMD_N)
      load_active <= 1'b0;
  end

  // ==========================================================
  // Address counters
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      write_addr <= `SRT_ADDR_RESET;
    else if (SYNC_LOST)
      write_addr <= `SRT_ADDR_RESET;
    else if (load_active && WRITE_STROBE)
      write_addr <= write_addr + 4'h1;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      read_addr <= `SRT_ADDR_RESET;
    else if (SYNC_LOST)
      read_addr <= `SRT_ADDR_RESET;
    else if (WORD_TAKE && !load_active)
      read_addr <= read_addr + 4'h1;
  end

  // Two-way address selector
  assign mem_addr = load_active ? write_addr : read_addr;

  // ==========================================================
  // Buffer storage
  // No overrun guard: the controller sends sixteen words at most
  genvar gi;
  generate
    for (gi = 0; gi < `SRT_BUF_WORDS; gi++)
    begin : g_word
      always_ff @(posedge CLOCK)
      begin
        if (load_active && WRITE_STROBE && mem_addr == srt_addr_t'(gi))
          mem[gi] <= WRITE_DATA;
      end
    end
  endgenerate

  // Word handed to the data shift register when taken
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      read_word <= 16'h0000;
    else if (WORD_TAKE && !load_active)
      read_word <= mem[mem_addr];
  end

  assign READ_WORD         = read_word;
  assign BUFFER_ADDR_MATCH = (write_addr == read_addr);
  assign WRITE_ADDR        = write_addr;
  assign READ_ADDR         = read_addr;

  // ==========================================================
  // Idle byte hold register, system clock domain
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      idle_hold_reg <= `SRT_IDLE_HOLD_RESET;
    else if (LOAD_IDLE)
      idle_hold_reg <= IDLE_DATA;
  end

  // Transfer waits for the next gated edge, one edge late at most
  always_comb
  begin
    next_idle_state = idle_state;
    case (idle_state)
      SRT_LD_IDLE: if (LOAD_IDLE) next_idle_state = SRT_LD_ARM;
      SRT_LD_ARM:  next_idle_state = SRT_LD_WAIT;
      SRT_LD_WAIT: if (gated_tx_rise) next_idle_state = SRT_LD_IDLE;
      default:     next_idle_state = SRT_LD_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      idle_state <= SRT_LD_IDLE;
    else
      idle_state <= next_idle_state;
  end

  assign idle_pending = (idle_state == SRT_LD_WAIT);

  // ==========================================================
  // Idle loop shifter, stepped by the gated transmit clock
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      idle_tx_shifter <= `SRT_IDLE_HOLD_RESET;
    else if (gated_tx_rise && idle_pending)
      idle_tx_shifter <= idle_hold_reg;
    else if (gated_tx_rise)
      idle_tx_shifter <= {idle_tx_shifter[6:0], idle_tx_shifter[7]};
  end

  assign IDLE_STREAM = idle_tx_shifter[7];

  // ==========================================================
  // Idle deserialiser and comparator
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      idle_rx_deserializer <= 8'h00;
    else if (gated_tx_rise)
      idle_rx_deserializer <= {idle_rx_deserializer[6:0], IDLE_STREAM};
  end

  // Pattern strapped two bits rotated; the match is registered, so the strobe comes one clock after the gated edge
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      idle_strobe <= 1'b0;
    else
      idle_strobe <= gated_tx_rise && (idle_rx_deserializer ==
        rotl(`SRT_IDLE_PATTERN, `SRT_IDLE_ROTATE));
  end

  assign IDLE_STROBE = idle_strobe;

  // ==========================================================
  // Checks
  chk_empty_clear: assert property (@(posedge CLOCK)
    disable iff (RST) SYNC_LOST |=> BUFFER_ADDR_MATCH)
    else $error("Match flag not high after counter clear");
  chk_write_step: assert property (@(posedge CLOCK)
    disable iff (RST) load_active && WRITE_STROBE && !SYNC_LOST |=>
      write_addr == $past(write_addr) + 4'h1)
    else $error("Write counter did not advance");
  chk_read_step: assert property (@(posedge CLOCK)
    disable iff (RST) WORD_TAKE && !load_active && !SYNC_LOST |=>
      read_addr == $past(read_addr) + 4'h1)
    else $error("Read counter did not advance");
  chk_read_frozen: assert property (@(posedge CLOCK)
    disable iff (RST) load_active && !SYNC_LOST |=> $stable(read_addr))
    else $error("Read counter moved during a load");
  chk_sync_clear: assert property (@(posedge CLOCK)
    disable iff (RST) SYNC_LOST |=> write_addr == 4'h0 && read_addr == 4'h0)
    else $error("Counters not cleared on sync loss");
  chk_sel_read: assert property (@(posedge CLOCK)
    disable iff (RST) !load_active |-> mem_addr == read_addr)
    else $error("Selector not on read counter");
  chk_load_open: assert property (@(posedge CLOCK)
    disable iff (RST) $fell(LOAD_WORDS_CMD_N) ##1 !LOAD_WORDS_CMD_N
      |=> load_active)
    else $error("Load window did not open");
  chk_load_close: assert property (@(posedge CLOCK)
    disable iff (RST) load_active && LOAD_WORDS_CMD_N ##1 LOAD_WORDS_CMD_N
      |=> !load_active)
    else $error("Load window did not close");
  chk_idle_xfer: assert property (@(posedge CLOCK)
    disable iff (RST) gated_tx_rise && idle_pending |=>
      idle_tx_shifter == $past(idle_hold_reg))
    else $error("Idle byte not moved into the shifter");
  chk_idle_loop: assert property (@(posedge CLOCK)
    disable iff (RST) gated_tx_rise && !idle_pending |=>
      idle_tx_shifter[0] == $past(idle_tx_shifter[7]))
    else $error("Idle loop feedback broken");
  chk_pause_hold: assert property (@(posedge CLOCK)
    disable iff (RST) tx_rise && !ZERO_INSERT_PAUSE_N |=> $stable(idle_tx_shifter))
    else $error("Idle shifter moved during pause");
  chk_gated_skip: assert property (@(posedge CLOCK)
    disable iff (RST) tx_rise && !ZERO_INSERT_PAUSE_N |=> !GATED_TX_CLOCK [*4])
    else $error("Gated clock pulsed in a skipped period");
  chk_gated_run: assert property (@(posedge CLOCK)
    disable iff (RST) gated_tx_rise |=> GATED_TX_CLOCK [*4] ##1 !GATED_TX_CLOCK)
    else $error("Gated clock high time is not four cycles");
  chk_strobe_cause: assert property (@(posedge CLOCK)
    disable iff (RST) idle_strobe |-> $past(gated_tx_rise))
    else $error("Idle strobe without gated edge");
  chk_strobe_single: assert property (@(posedge CLOCK)
    disable iff (RST) idle_strobe |=> !idle_strobe)
    else $error("Idle strobe wider than one cycle");
endmodule : srt_tx_front_end
`default_nettype wire

//--- srt_report_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Report controller: loads one report per call
module srt_report_ctrl_model
(
  input  wire logic          CLOCK,
  output logic               load_words_cmd_n,
  output logic               write_strobe,
  output srt_pkg::srt_word_t write_data
);
  import srt_pkg::*;

  initial
  begin
    load_words_cmd_n = 1'b1;
    write_strobe     = 1'b0;
    write_data       = 16'h5a5a;
  end

  // Strobe held one cycle per word; never beyond the buffer size
  task automatic load_report(input int n, input srt_word_t base);
    int m;
    m = (n > 16) ? 16 : n;
    load_words_cmd_n = 1'b0;
    repeat (3) @(posedge CLOCK);
    #1;
    write_strobe = 1'b1;
    for (int j = 0; j < m; j++)
    begin
      write_data = srt_word_t'(base + j);
      @(posedge CLOCK);
      #1;
    end
    write_strobe     = 1'b0;
    load_words_cmd_n = 1'b1;
    // Released bus must not keep showing the last word
    write_data       = ~write_data;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask : load_report

  task automatic stray_strobe();
    write_strobe = 1'b1;
    @(posedge CLOCK);
    #1;
    write_strobe = 1'b0;
  endtask : stray_strobe
endmodule : srt_report_ctrl_model

`default_nettype wire

//--- tb_srt_tx_front_end.sv
`timescale 1ns/1ps
`default_nettype none

module tb_srt_tx_front_end;
  import srt_pkg::*;

  typedef struct {int n; srt_addr_t wa; logic m;} srt_row_t;

  logic      CLOCK     = 1'b0;
  logic      RST       = 1'b1;
  logic      pause_n   = 1'b1;
  logic      take      = 1'b0;
  logic      sync_lost = 1'b0;
  logic      load_idle = 1'b0;
  srt_byte_t idle_data = 8'h7e;
  wire logic cmd_n;
  wire logic strobe;
  wire logic txc;
  wire logic gtxc;
  wire logic txr;
  wire logic gtxr;
  wire logic match;
  wire logic istr;
  wire logic istb;
  srt_word_t wdata;
  srt_word_t rword;
  srt_addr_t waddr;
  srt_addr_t raddr;
  srt_word_t base;
  int        n_mismatch  = 0;
  int        comparisons = 0;
  int        k;
  int        hi;
  int        rs;
  int        gs;
  srt_row_t  rows [4] = '{'{1, 4'h1, 1'b0}, '{3, 4'h3, 1'b0},
                         '{15, 4'hf, 1'b0}, '{16, 4'h0, 1'b1}};

  always #5 CLOCK = ~CLOCK;

  srt_report_ctrl_model rc
  (
    .CLOCK            (CLOCK),
    .load_words_cmd_n (cmd_n),
    .write_strobe     (strobe),
    .write_data       (wdata)
  );

  srt_tx_front_end dut
  (
    .CLOCK               (CLOCK),
    .RST                 (RST),
    .ZERO_INSERT_PAUSE_N (pause_n),
    .LOAD_WORDS_CMD_N    (cmd_n),
    .WRITE_STROBE        (strobe),
    .WRITE_DATA          (wdata),
    .WORD_TAKE           (take),
    .SYNC_LOST           (sync_lost),
    .LOAD_IDLE           (load_idle),
    .IDLE_DATA           (idle_data),
    .TX_CLOCK            (txc),
    .GATED_TX_CLOCK      (gtxc),
    .TX_RISE             (txr),
    .GATED_TX_RISE       (gtxr),
    .READ_WORD           (rword),
    .BUFFER_ADDR_MATCH   (match),
    .WRITE_ADDR          (waddr),
    .READ_ADDR           (raddr),
    .IDLE_STREAM         (istr),
    .IDLE_STROBE         (istb)
  );

  // ====
  // Helpers
  task automatic tick();
    @(posedge CLOCK);
    #1;
  endtask : tick

  task automatic chk_bit(input logic got, input logic exp, input string s);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                         input string s);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk_val

  task automatic wait_rise();
    k = 0;
    while (txr !== 1'b1 && k < 20)
    begin
      tick();
      k++;
    end
  endtask : wait_rise

  // Cycles from one idle strobe to the next
  task automatic strobe_gap(output int gap);
    k = 0;
    while (istb !== 1'b1 && k < 300)
    begin
      tick();
      k++;
    end
    tick();
    gap = 1;
    while (istb !== 1'b1 && gap < 300)
    begin
      tick();
      gap++;
    end
  endtask : strobe_gap

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  // ====
  // Tests
  initial
  begin
    repeat (5) tick();
    chk_val(waddr, 16'h0, "reset waddr");
    chk_val(raddr, 16'h0, "reset raddr");
    chk_bit(match, 1'b1, "reset match");
    chk_bit(txc, 1'b0, "reset txclk");
    RST = 1'b0;
    wait_rise();
    rs = 0;
    hi = 0;
    gs = 0;
    repeat (8)
    begin
      tick();
      rs += txr;
      hi += txc;
      gs += gtxc;
    end
    chk_val(rs, 1, "rise period");
    chk_val(hi, 4, "duty");
    chk_val(gs, 4, "gated duty");
    pause_n = 1'b0;
    rs = 0;
    hi = 0;
    gs = 0;
    repeat (8)
    begin
      tick();
      rs += txr;
      hi += gtxr;
      gs += gtxc;
    end
    pause_n = 1'b1;
    chk_val(rs, 1, "free clock");
    chk_val(hi, 0, "gated skip");
    chk_val(gs, 0, "gated level skip");
    for (int i = 0; i < 4; i++)
    begin
      sync_lost = 1'b1;
      tick();
      sync_lost = 1'b0;
      tick();
      chk_val(waddr, 16'h0, "sync clr");
      chk_val(raddr, 16'h0, "sync clr r");
      base = srt_word_t'(16'ha000 + 16'h0100 * i);
      rc.load_report(rows[i].n, base);
      chk_val(waddr, rows[i].wa, "waddr");
      chk_bit(match, rows[i].m, "match load");
      take = 1'b1;
      for (int j = 0; j < rows[i].n; j++)
      begin
        tick();
        chk_val(rword, srt_word_t'(base + j), "word");
      end
      take = 1'b0;
      chk_val(raddr, rows[i].wa, "raddr");
      chk_bit(match, 1'b1, "empty");
    end
    rc.stray_strobe();
    tick();
    chk_val(waddr, 16'h0, "stray");
    strobe_gap(hi);
    chk_val(hi, 64, "idle gap");
    // One frame of the looping pattern carries its six ones
    rs = 0;
    repeat (64)
    begin
      tick();
      if (gtxr === 1'b1)
        rs += istr;
    end
    chk_val(rs, 6, "idle ones");
    idle_data = 8'h55;
    load_idle = 1'b1;
    tick();
    load_idle = 1'b0;
    repeat (100) tick();
    rs = 0;
    repeat (130)
    begin
      tick();
      rs += istb;
    end
    chk_val(rs, 0, "no strobe");
    idle_data = 8'h7e;
    load_idle = 1'b1;
    tick();
    load_idle = 1'b0;
    strobe_gap(hi);
    chk_val(hi, 64, "reload gap");
    // A take pulse inside the load window must be ignored
    fork
      rc.load_report(3, 16'h0123);
      begin
        repeat (4) tick();
        take = 1'b1;
        tick();
        take = 1'b0;
      end
    join
    chk_val(waddr, 16'h3, "load three");
    chk_val(raddr, 16'h0, "take refused");
    RST = 1'b1;
    tick();
    chk_val(waddr, 16'h0, "rst mid");
    chk_bit(match, 1'b1, "rst match");
    chk_bit(istb, 1'b0, "rst strobe");
    RST = 1'b0;
    repeat (3) tick();
    chk_bit(txr, 1'b1, "restart rise");
    report_and_stop();
  end
endmodule : tb_srt_tx_front_end

`default_nettype wire
